// [src/sea_system_error_aggregator.sv]
`timescale 1ns/1ps
`include "sea_map.svh"
// Notes on behaviour
// R1: merge seven error sources into one interrupt
// R2: latch source only while its mask clear
// R3: software sets mask and flags before use
// R4: polarity bit selects status pin active level
// R5: status pin active low after reset
// R6: software may force and clear status pin
// R7: watchdog, vector fetch, manager nmi assert pin
// R8: watchdog prescaler divides by two to 4096
// R9: each nmi source has own flag
// R10: system reset clears all nmi flags
// R11: four further nmi sources accepted
// R12: interrupt holds while flags set until cleared
module sea_system_error_aggregator (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire sea_pkg::sea_addr_type PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CLOCK_CHECK_MONITOR0,
  input wire logic CLOCK_CHECK_MONITOR1,
  input wire logic CLOCK_CHECK_MONITOR2,
  input wire logic RAM_ACCESS_VIOLATION,
  input wire logic FLASH_CORRECTABLE_ERROR,
  input wire logic RAM_CORRECTABLE_ERROR,
  input wire logic EXTERNAL_MEMORY_ERROR1,
  input wire logic EXTERNAL_MEMORY_ERROR2,
  input wire logic WATCHDOG_RESET_EVENT,
  input wire logic VECTOR_FETCH_ERROR,
  input wire logic CONNECTIVITY_MANAGER_NMI,
  input wire logic [3:0] NMI_BASE_SOURCES,
  input wire logic BACKGROUND_CHECK_FAIL,
  input wire logic FIELDBUS_SLAVE_NMI_N,
  input wire logic MANAGER_NMI_WATCHDOG_RESET_N,
  input wire logic ANALYSIS_UNIT_NMI,
  output logic SYSTEM_ERROR_INTERRUPT,
  output logic ERROR_STATUS_PIN,
  output logic NMI_PENDING,
  output logic WATCHDOG_TICK
);
  import sea_pkg::*;

  // address decode, shared by the read mux and the write strobes
  // unmapped offsets fall through to none and answer with an error
  function automatic sea_reg_type reg_decode(input sea_addr_type addr);
    sea_reg_type sel;
    sel = SEA_REG_NONE;
    if (addr == `SEA_OFF_ERR_FLAG) begin
      sel = SEA_REG_ERR_FLAG;
    end else if (addr == `SEA_OFF_ERR_MASK) begin
      sel = SEA_REG_ERR_MASK;
    end else if (addr == `SEA_OFF_ERR_CTL) begin
      sel = SEA_REG_ERR_CTL;
    end else if (addr == `SEA_OFF_ERR_STAT) begin
      sel = SEA_REG_ERR_STAT;
    end else if (addr == `SEA_OFF_WD_CTL) begin
      sel = SEA_REG_WD_CTL;
    end else if (addr == `SEA_OFF_NMI_FLAG) begin
      sel = SEA_REG_NMI_FLAG;
    end
    return sel;
  endfunction

  sea_link_if u_link (); // carrier to the two helpers

  // apb side state
  logic [31:0] prdata_r; // read data, loaded in setup phase
  logic pready_r; // ready, high from the first edge after reset
  logic pslverr_r; // error answer for unmapped addresses
  // system error state
  sea_err_type mask_r; // set bit blocks latching
  sea_err_type flag_r; // latched error flags
  sea_err_type flag_nxt; // next flags
  logic irq_r; // merged interrupt
  // status pin state
  logic pol_r; // 1 = active high pin
  logic pol_nxt; // next polarity
  logic stat_r; // error status latched
  logic stat_nxt; // next status
  logic pin_r; // pin level
  sea_pre_sel_type pre_sel_r; // watchdog prescale select

  // apb phase decode
  wire setup = PSEL & ~PENABLE; // setup phase
  wire access_wr = PSEL & PENABLE & PWRITE & pready_r; // write takes effect here
  sea_reg_type cur_reg; // decoded target
  assign cur_reg = reg_decode(PADDR);
  wire wr_flag = access_wr & (cur_reg == SEA_REG_ERR_FLAG);
  wire wr_mask = access_wr & (cur_reg == SEA_REG_ERR_MASK);
  wire wr_ctl = access_wr & (cur_reg == SEA_REG_ERR_CTL);
  wire wr_wd = access_wr & (cur_reg == SEA_REG_WD_CTL);
  wire wr_nmi = access_wr & (cur_reg == SEA_REG_NMI_FLAG);

  // R1: merged source vector
  sea_err_type err_src; // raw error sources
  assign err_src[`SEA_ERR_CLK0] = CLOCK_CHECK_MONITOR0;
  assign err_src[`SEA_ERR_CLK1] = CLOCK_CHECK_MONITOR1;
  assign err_src[`SEA_ERR_CLK2] = CLOCK_CHECK_MONITOR2;
  assign err_src[`SEA_ERR_RAM_VIOL] = RAM_ACCESS_VIOLATION;
  assign err_src[`SEA_ERR_FLASH_CORR] = FLASH_CORRECTABLE_ERROR;
  assign err_src[`SEA_ERR_RAM_CORR] = RAM_CORRECTABLE_ERROR;
  // either external memory port feeds one bit
  assign err_src[`SEA_ERR_EXT_MEM] = EXTERNAL_MEMORY_ERROR1 | EXTERNAL_MEMORY_ERROR2;

  // R2: mask gates latching
  sea_err_type err_set; // unmasked events
  assign err_set = err_src & ~mask_r;
  sea_err_type flag_clr; // write-one-to-clear bits
  assign flag_clr = wr_flag ? PWDATA[`SEA_ERR_NUM-1:0] : '0;
  // R12: flags sticky, set wins
  assign flag_nxt = (flag_r & ~flag_clr) | err_set;

  // R4: polarity from control write
  assign pol_nxt = wr_ctl ? PWDATA[`SEA_CTL_POL_BIT] : pol_r;
  // software force and clear strobes
  wire stat_force = wr_ctl & PWDATA[`SEA_CTL_FORCE_BIT];
  wire stat_clear = wr_ctl & PWDATA[`SEA_CTL_CLEAR_BIT];
  // R7: extra pin sources
  wire stat_evt = WATCHDOG_RESET_EVENT | VECTOR_FETCH_ERROR | CONNECTIVITY_MANAGER_NMI;
  // status is latched so a one-cycle event still leaves a visible pin
  // R6: force sets, clear drops; a real event beats the clear
  assign stat_nxt = (stat_r & ~stat_clear) | stat_evt | stat_force;
  // pin level follows next state so the pin never lags the status bit
  wire pin_nxt = pol_nxt ? stat_nxt : ~stat_nxt;

  // codes above the top select are stored, and read back, as the top select
  // R8: clamp select to the divide range
  wire [`SEA_PRE_SEL_W-1:0] pre_wr = PWDATA[`SEA_PRE_SEL_W-1:0];
  wire sea_pre_sel_type pre_clamped = (pre_wr > `SEA_PRE_SEL_MAX) ? `SEA_PRE_SEL_MAX : pre_wr;

  // R11: further nmi sources, active low ones inverted
  sea_nmi_type nmi_src; // all nmi sources, active high
  assign nmi_src[3:0] = NMI_BASE_SOURCES;
  assign nmi_src[`SEA_NMI_BG_CHECK] = BACKGROUND_CHECK_FAIL;
  assign nmi_src[`SEA_NMI_FIELDBUS] = ~FIELDBUS_SLAVE_NMI_N;
  assign nmi_src[`SEA_NMI_MGR_WD] = ~MANAGER_NMI_WATCHDOG_RESET_N;
  assign nmi_src[`SEA_NMI_ANALYSIS] = ANALYSIS_UNIT_NMI;
  assign u_link.nmi_src = nmi_src;
  assign u_link.nmi_clr = wr_nmi ? PWDATA[`SEA_NMI_NUM-1:0] : '0;
  assign u_link.pre_sel = pre_sel_r;

  // read mux; unused upper bits read as zero
  // status register shows the pin level beside the latched status bit
  logic [31:0] rdata_nxt; // data for the current address
  assign rdata_nxt =
    (cur_reg == SEA_REG_ERR_FLAG) ? {25'h0000000, flag_r} :
    (cur_reg == SEA_REG_ERR_MASK) ? {25'h0000000, mask_r} :
    (cur_reg == SEA_REG_ERR_CTL) ? {31'h00000000, pol_r} :
    (cur_reg == SEA_REG_ERR_STAT) ? {30'h00000000, pin_r, stat_r} :
    (cur_reg == SEA_REG_WD_CTL) ? {28'h0000000, pre_sel_r} :
    (cur_reg == SEA_REG_NMI_FLAG) ? {24'h000000, u_link.nmi_flag} : 32'h00000000;

  // apb answer registers; zero wait states keep the slave simple
  // read data is captured in the setup phase, so a read returns the state
  // one cycle before the access edge; that staleness is the price paid
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup) begin
        prdata_r <= PWRITE ? 32'h00000000 : rdata_nxt;
        pslverr_r <= (cur_reg == SEA_REG_NONE);
      end
    end
  end

  // system error flags, mask and interrupt
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      // all sources start masked; software opts in per source
      mask_r <= `SEA_MASK_RST;
      flag_r <= '0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      // interrupt follows the next flags so it never trails them
      irq_r <= |flag_nxt;
      if (wr_mask) begin
        mask_r <= PWDATA[`SEA_ERR_NUM-1:0];
      end
    end
  end

  // status pin, polarity and prescale select
  always_ff @(posedge SYS_CLK) begin
    // R5: reset leaves pin inactive high
    if (!RST_N) begin
      pol_r <= `SEA_POL_RST;
      stat_r <= 1'b0;
      pin_r <= `SEA_PIN_RST;
      pre_sel_r <= `SEA_PRE_SEL_RST;
    end else begin
      // polarity, status and pin load together so the pin matches both
      pol_r <= pol_nxt;
      stat_r <= stat_nxt;
      pin_r <= pin_nxt;
      if (wr_wd) begin
        pre_sel_r <= pre_clamped;
      end
    end
  end

  // nmi capture flags, wiped by the system reset
  sea_nmi_flags u_nmi (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lnk(u_link.nmi)
  );

  // watchdog clock prescaler
  sea_wd_prescaler #(
    .CNT_W(`SEA_PRE_CNT_W)
  ) u_pre (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lnk(u_link.pre)
  );

  // outputs straight from flops
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign SYSTEM_ERROR_INTERRUPT = irq_r;
  assign ERROR_STATUS_PIN = pin_r;
  assign NMI_PENDING = u_link.nmi_pend;
  assign WATCHDOG_TICK = u_link.pre_tick;

  // checks run on the system clock and stand down while reset is low
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // merged interrupt and flags
  a_merge_raise: assert property ( // R1
    (|err_set) |=> SYSTEM_ERROR_INTERRUPT)
    else $error("unmasked error did not raise interrupt");
  a_mask_gate: assert property ( // R2
    ((flag_r & ~$past(flag_r)) & ~$past(err_set)) == '0)
    else $error("flag set without an unmasked source");
  a_flag_sticky: assert property ( // R12
    $past(RST_N) |-> ((($past(flag_r) & ~flag_r) & ~$past(flag_clr)) == '0))
    else $error("flag dropped without software clear");
  a_irq_level: assert property ( // R12
    SYSTEM_ERROR_INTERRUPT == (|flag_r))
    else $error("interrupt does not match flags");
  // status pin
  a_pin_polarity: assert property ( // R4
    ERROR_STATUS_PIN == (pol_r ? stat_r : !stat_r))
    else $error("pin level disagrees with polarity");
  a_reset_pin: assert property ( // R5
    $past(!RST_N) |-> (ERROR_STATUS_PIN && !pol_r))
    else $error("pin not inactive low-polarity after reset");
  a_force_pin: assert property ( // R6
    stat_force |=> (stat_r && (ERROR_STATUS_PIN == pol_r)))
    else $error("force did not assert the pin");
  a_clear_pin: assert property ( // R6
    (stat_clear && !stat_force && !stat_evt) |=> !stat_r)
    else $error("clear did not drop the pin");
  a_extra_src: assert property ( // R7
    stat_evt |=> stat_r)
    else $error("extra source did not assert the pin");
  // prescaler, nmi capture and apb ready
  a_pre_range: assert property ( // R8
    pre_sel_r <= `SEA_PRE_SEL_MAX)
    else $error("prescale select out of range");
  a_fieldbus_nmi: assert property ( // R11
    !FIELDBUS_SLAVE_NMI_N |=> u_link.nmi_flag[`SEA_NMI_FIELDBUS])
    else $error("fieldbus nmi not captured");
  a_nmi_reset: assert property ( // R10
    $past(!RST_N) |-> (u_link.nmi_flag == '0))
    else $error("nmi flags not cleared by reset");
  a_apb_ready: assert property (
    (PSEL && PENABLE) |-> PREADY)
    else $error("access phase without ready");

  // register writes and the bus answer
  a_mask_write: assert property ( // R2
    wr_mask |=> (mask_r == $past(PWDATA[`SEA_ERR_NUM-1:0])))
    else $error("mask write did not land");
  a_pol_write: assert property ( // R4
    wr_ctl |=> (pol_r == $past(PWDATA[`SEA_CTL_POL_BIT])))
    else $error("polarity write did not land");
  a_irq_clear: assert property ( // R12
    (((flag_r & ~flag_clr) == '0) && (err_set == '0)) |=> !SYSTEM_ERROR_INTERRUPT)
    else $error("interrupt stayed high with no flag left");
  a_pslverr_map: assert property (
    setup |=> (PSLVERR == ($past(cur_reg) == SEA_REG_NONE)))
    else $error("error answer disagrees with address map");
  a_ready_reset: assert property (
    $past(!RST_N) |-> !PREADY)
    else $error("ready high at first edge after reset");

  // main scenarios
  c_irq_raise: cover property (!SYSTEM_ERROR_INTERRUPT ##1 SYSTEM_ERROR_INTERRUPT);
  c_force_pin: cover property (stat_force ##1 stat_r);
  c_nmi_cap: cover property (!FIELDBUS_SLAVE_NMI_N ##1 NMI_PENDING);
  c_tick: cover property (WATCHDOG_TICK);
  c_pin_clear: cover property (stat_clear ##1 !stat_r);
endmodule

// [shared/sea_map.svh]
`ifndef SEA_MAP_SVH
`define SEA_MAP_SVH
// apb register byte offsets
`define SEA_ADDR_W 12
`define SEA_OFF_ERR_FLAG 12'h000
`define SEA_OFF_ERR_MASK 12'h004
`define SEA_OFF_ERR_CTL 12'h008
`define SEA_OFF_ERR_STAT 12'h00C
`define SEA_OFF_WD_CTL 12'h010
`define SEA_OFF_NMI_FLAG 12'h014
// vector widths
`define SEA_ERR_NUM 7
`define SEA_NMI_NUM 8
// error flag bit positions
`define SEA_ERR_CLK0 0
`define SEA_ERR_CLK1 1
`define SEA_ERR_CLK2 2
`define SEA_ERR_RAM_VIOL 3
`define SEA_ERR_FLASH_CORR 4
`define SEA_ERR_RAM_CORR 5
`define SEA_ERR_EXT_MEM 6
// error control bit positions
`define SEA_CTL_POL_BIT 0
`define SEA_CTL_FORCE_BIT 1
`define SEA_CTL_CLEAR_BIT 2
// nmi flag bit positions
`define SEA_NMI_BG_CHECK 4
`define SEA_NMI_FIELDBUS 5
`define SEA_NMI_MGR_WD 6
`define SEA_NMI_ANALYSIS 7
// reset values
`define SEA_MASK_RST 7'h7F
`define SEA_POL_RST 1'h0
`define SEA_PIN_RST 1'h1
`define SEA_PRE_SEL_RST 4'h8
// prescaler select 0 gives divide by 2, 11 gives divide by 4096
`define SEA_PRE_SEL_W 4
`define SEA_PRE_SEL_MAX 4'hB
`define SEA_PRE_CNT_W 12
`endif

// [shared/sea_pkg.sv]
`include "sea_map.svh"
package sea_pkg;
  // register selected by an apb address
  typedef enum {
    SEA_REG_NONE,
    SEA_REG_ERR_FLAG,
    SEA_REG_ERR_MASK,
    SEA_REG_ERR_CTL,
    SEA_REG_ERR_STAT,
    SEA_REG_WD_CTL,
    SEA_REG_NMI_FLAG
  } sea_reg_type;
  // merged system error sources
  typedef logic [`SEA_ERR_NUM-1:0] sea_err_type;
  // nmi capture sources
  typedef logic [`SEA_NMI_NUM-1:0] sea_nmi_type;
  // prescaler select code
  typedef logic [`SEA_PRE_SEL_W-1:0] sea_pre_sel_type;
  // apb address
  typedef logic [`SEA_ADDR_W-1:0] sea_addr_type;
endpackage

// [shared/sea_link_if.sv]
`timescale 1ns/1ps
interface sea_link_if;
  import sea_pkg::*;
  sea_nmi_type nmi_src; // nmi event sources, active high
  sea_nmi_type nmi_clr; // write-one-to-clear mask, one-cycle pulse
  sea_nmi_type nmi_flag; // latched nmi flags
  logic nmi_pend; // any nmi flag set
  sea_pre_sel_type pre_sel; // prescaler select
  logic pre_tick; // one pulse per divided period
  modport top (output nmi_src, nmi_clr, pre_sel, input nmi_flag, nmi_pend, pre_tick);
  modport nmi (input nmi_src, nmi_clr, output nmi_flag, nmi_pend);
  modport pre (input pre_sel, output pre_tick);
endinterface

// [src/sea_nmi_flags.sv]
`timescale 1ns/1ps
module sea_nmi_flags (
  input wire logic clk,
  input wire logic rst_n,
  sea_link_if.nmi lnk
);
  import sea_pkg::*;
  sea_nmi_type flag_r; // latched nmi flags
  sea_nmi_type flag_nxt; // next flags
  logic pend_r; // any flag pending

  // set wins over a clear in the same cycle
  // R9: per source flag
  assign flag_nxt = (flag_r & ~lnk.nmi_clr) | lnk.nmi_src;

  // flags cleared by the system reset, so any system reset wipes them
  always_ff @(posedge clk) begin
    // R10: system reset clears
    if (!rst_n) begin
      flag_r <= '0;
      pend_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      pend_r <= |flag_nxt;
    end
  end

  assign lnk.nmi_flag = flag_r;
  assign lnk.nmi_pend = pend_r;

  a_nmi_hold: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ((($past(flag_r) & ~flag_r) & ~$past(lnk.nmi_clr)) == '0))
    else $error("nmi flag dropped without a clear");
  a_nmi_pend: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    (|lnk.nmi_src) |=> lnk.nmi_pend)
    else $error("nmi source did not raise pending");
endmodule

// [src/sea_wd_prescaler.sv]
`timescale 1ns/1ps
`include "sea_map.svh"
module sea_wd_prescaler #(
  parameter int CNT_W = `SEA_PRE_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  sea_link_if.pre lnk
);
  import sea_pkg::*;
  logic [CNT_W-1:0] cnt_r; // divider count
  logic [CNT_W-1:0] cnt_nxt; // next count
  logic [CNT_W-1:0] last; // terminal count for this select
  logic wrap; // period complete
  logic tick_r; // divided tick

  // period is two to the power of select plus one
  // R8: programmable divide
  assign last = CNT_W'((CNT_W+1)'(2) << lnk.pre_sel) - CNT_W'(1);
  // compare with >= so a smaller select after a change wraps at once
  assign wrap = (cnt_r >= last);
  assign cnt_nxt = wrap ? '0 : cnt_r + CNT_W'(1);

  // count and tick register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= wrap;
    end
  end

  assign lnk.pre_tick = tick_r;

  a_tick_spacing: assert property ( // R8
    @(posedge clk) disable iff (!rst_n)
    tick_r |=> !tick_r)
    else $error("prescaler ticked twice in a row");
endmodule

// [sim/sea_src_model.sv]
`timescale 1ns/1ps
// far side: error sources and nmi requesters, each event lasts one cycle
module sea_src_model (
  input wire logic clk,
  input wire logic [7:0] err_req,
  input wire logic [2:0] pin_req,
  input wire logic [7:0] nmi_req,
  output logic [7:0] err_line,
  output logic [2:0] pin_line,
  output logic [7:0] nmi_line
);
  // strobes are registered so they launch just after an edge, like real logic
  always_ff @(posedge clk) begin
    err_line <= err_req;
    pin_line <= pin_req;
    // lines 5 and 6 idle high
    nmi_line <= nmi_req ^ 8'h60;
  end
endmodule

// [sim/test_system_error_aggregator.sv]
`timescale 1ns/1ps
`include "sea_map.svh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %s exp %0h got %0h", nm, e, a); end end
module test_system_error_aggregator;
  import sea_pkg::*;
  typedef struct {logic [31:0] d; logic e;} sea_exp_type;
  logic SYS_CLK, RST_N, psel, pen, pwr, PREADY, PSLVERR;
  logic SYSTEM_ERROR_INTERRUPT, ERROR_STATUS_PIN, NMI_PENDING, WATCHDOG_TICK;
  sea_addr_type paddr;
  logic [31:0] pwdata, PRDATA, seed;
  logic [7:0] err_req, nmi_req, err_line, nmi_line, acc;
  logic [2:0] pin_req, pin_line;
  logic [6:0] m;
  sea_exp_type q[$];
  sea_exp_type ex;
  int n_fail = 0;
  int n_tests = 0;
  int g;
  int b;
  sea_src_model u_src (.clk(SYS_CLK), .err_req(err_req), .pin_req(pin_req),
    .nmi_req(nmi_req), .err_line(err_line), .pin_line(pin_line), .nmi_line(nmi_line));
  sea_system_error_aggregator u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CLOCK_CHECK_MONITOR0(err_line[0]),
    .CLOCK_CHECK_MONITOR1(err_line[1]), .CLOCK_CHECK_MONITOR2(err_line[2]),
    .RAM_ACCESS_VIOLATION(err_line[3]), .FLASH_CORRECTABLE_ERROR(err_line[4]),
    .RAM_CORRECTABLE_ERROR(err_line[5]), .EXTERNAL_MEMORY_ERROR1(err_line[6]),
    .EXTERNAL_MEMORY_ERROR2(err_line[7]), .WATCHDOG_RESET_EVENT(pin_line[0]),
    .VECTOR_FETCH_ERROR(pin_line[1]), .CONNECTIVITY_MANAGER_NMI(pin_line[2]),
    .NMI_BASE_SOURCES(nmi_line[3:0]), .BACKGROUND_CHECK_FAIL(nmi_line[4]),
    .FIELDBUS_SLAVE_NMI_N(nmi_line[5]), .MANAGER_NMI_WATCHDOG_RESET_N(nmi_line[6]),
    .ANALYSIS_UNIT_NMI(nmi_line[7]), .SYSTEM_ERROR_INTERRUPT(SYSTEM_ERROR_INTERRUPT),
    .ERROR_STATUS_PIN(ERROR_STATUS_PIN), .NMI_PENDING(NMI_PENDING),
    .WATCHDOG_TICK(WATCHDOG_TICK));
  // free running clock, 10 ns period
  initial begin
    SYS_CLK = 0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // fixed-seed pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one apb transfer, entered just after a rising edge; reads note their expectation
  task apb(input logic w, input sea_addr_type a, input logic [31:0] d, input logic ee);
    if (!w) q.push_back('{d, ee});
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge SYS_CLK);
    pen <= 1;
    // no cycle count is assumed; only the hang guard ends this wait
    do begin @(posedge SYS_CLK); end while (PREADY !== 1'b1);
    psel <= 0;
    pen <= 0;
    // an idle edge keeps two transfers from touching psel in one step
    @(posedge SYS_CLK);
  endtask
  task wr(input sea_addr_type a, input logic [31:0] d);
    apb(1, a, d, 0);
  endtask
  task rd(input sea_addr_type a, input logic [31:0] e, input logic ee);
    apb(0, a, e, ee);
  endtask
  // one-cycle request to the far side, then time for the flags to settle
  task pulse(input logic [7:0] e, input logic [2:0] p, input logic [7:0] n);
    err_req <= e;
    pin_req <= p;
    nmi_req <= n;
    @(posedge SYS_CLK);
    err_req <= 0;
    pin_req <= 0;
    nmi_req <= 0;
    repeat (3) @(posedge SYS_CLK);
  endtask
  // cycles between two watchdog ticks
  task gap(output int n);
    int c;
    c = 0;
    while (WATCHDOG_TICK !== 1'b1 && c < 9000) begin @(posedge SYS_CLK); c++; end
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (WATCHDOG_TICK !== 1'b1 && n < 9000);
  endtask
  task tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // read monitor: oldest note against the data taken at the access edge
  always @(posedge SYS_CLK) begin
    if (psel && pen && !pwr && PREADY === 1'b1) begin
      ex = q.pop_front();
      `CHK("prdata", ex.d, PRDATA)
      `CHK("pslverr", ex.e, PSLVERR)
    end
  end
  // hang guard: the prescaler sweep needs about 25k cycles, so allow 40k
  initial begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; RST_N = 0;
    err_req = 0; pin_req = 0; nmi_req = 0; seed = 32'd65632;
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1;
    @(posedge SYS_CLK);
    `CHK("pin", 1'b1, ERROR_STATUS_PIN)
    rd(`SEA_OFF_ERR_MASK, 32'h7F, 0);
    rd(12'h020, 32'h0, 1);
    pulse(8'hFF, 0, 0);
    rd(`SEA_OFF_ERR_FLAG, 32'h0, 0);
    `CHK("irq", 1'b0, SYSTEM_ERROR_INTERRUPT)
    seed = lfsr(seed);
    m = seed[6:0];
    wr(`SEA_OFF_ERR_MASK, {25'h0, m});
    pulse(8'hFF, 0, 0);
    rd(`SEA_OFF_ERR_FLAG, {25'h0, ~m}, 0);
    wr(`SEA_OFF_ERR_FLAG, 32'h7F);
    wr(`SEA_OFF_ERR_MASK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      b = (i < 7) ? i : 6;
      pulse(8'h1 << i, 0, 0);
      `CHK("irq", 1'b1, SYSTEM_ERROR_INTERRUPT)
      rd(`SEA_OFF_ERR_FLAG, 32'h1 << b, 0);
      wr(`SEA_OFF_ERR_FLAG, 32'h1 << b);
      `CHK("irq", 1'b0, SYSTEM_ERROR_INTERRUPT)
    end
    $display("test errors done");
    wr(`SEA_OFF_ERR_CTL, 32'h2);
    `CHK("pin", 1'b0, ERROR_STATUS_PIN)
    rd(`SEA_OFF_ERR_STAT, 32'h1, 0);
    wr(`SEA_OFF_ERR_CTL, 32'h4);
    `CHK("pin", 1'b1, ERROR_STATUS_PIN)
    wr(`SEA_OFF_ERR_CTL, 32'h1);
    `CHK("pin", 1'b0, ERROR_STATUS_PIN)
    rd(`SEA_OFF_ERR_CTL, 32'h1, 0);
    for (int j = 0; j < 3; j++) begin
      pulse(0, 3'h1 << j, 0);
      `CHK("pin", 1'b1, ERROR_STATUS_PIN)
      rd(`SEA_OFF_ERR_STAT, 32'h3, 0);
      wr(`SEA_OFF_ERR_CTL, 32'h5);
      `CHK("pin", 1'b0, ERROR_STATUS_PIN)
    end
    $display("test pin done");
    acc = 0;
    for (int i = 0; i < 8; i++) begin
      pulse(0, 0, 8'h1 << i);
      acc = acc | (8'h1 << i);
      rd(`SEA_OFF_NMI_FLAG, {24'h0, acc}, 0);
      `CHK("nmi", 1'b1, NMI_PENDING)
    end
    RST_N <= 0;
    @(posedge SYS_CLK);
    RST_N <= 1;
    @(posedge SYS_CLK);
    `CHK("nmi", 1'b0, NMI_PENDING)
    rd(`SEA_OFF_NMI_FLAG, 32'h0, 0);
    `CHK("pin", 1'b1, ERROR_STATUS_PIN)
    $display("test nmi done");
    rd(`SEA_OFF_WD_CTL, 32'h8, 0);
    for (int s = 0; s < 12; s++) begin
      wr(`SEA_OFF_WD_CTL, s);
      gap(g);
      gap(g);
      `CHK("tick", 2 << s, g)
    end
    wr(`SEA_OFF_WD_CTL, 32'hF);
    rd(`SEA_OFF_WD_CTL, 32'hB, 0);
    $display("test watchdog done");
    tally_and_finish;
  end
endmodule
